/* File: verilog/adc_readout_pkg.sv */
// Operation
// - full input span maps to codes 80d2..7f2e, clamped at plus or minus 32558
// - negative inputs are two's complement, sign in bit 15 of the sample
// - sample sits in bits 31:16; inputs 0,1,4,5 group 0, inputs 2,3,6,7 group 1
// - inputs 0,1,4,5 start converting on the phase clock rising edge
// - inputs 2,3,6,7 start converting on the phase clock falling edge
// - bit pair 2n,2n+1 of the port word picks input n filter cut-off
// - converter clock divider defaults to 5, may be 4, nothing else
// - converter settings reset: control fffffc01, delay 0, header 1, strobe fffffc, utos 0
// - port control and polarity reset to zero, direction to 0000ffff
// - module answers without error only when the address carries its switch index; other indexes get an error answer
package adc_readout_pkg;

  // register byte offsets inside one module window
  localparam logic [7:0] OFF_SAMPLE0 = 8'h00;
  localparam logic [7:0] OFF_FILTER = 8'h20;
  localparam logic [7:0] OFF_PORT_DIR = 8'h24;
  localparam logic [7:0] OFF_PORT_POL = 8'h28;
  localparam logic [7:0] OFF_PORT_CTL = 8'h2c;
  localparam logic [7:0] OFF_CLK_DIV = 8'h30;
  localparam logic [7:0] OFF_CONV_CTL = 8'h34;
  localparam logic [7:0] OFF_SAMPLE_DLY = 8'h38;
  localparam logic [7:0] OFF_HEADER = 8'h3c;
  localparam logic [7:0] OFF_STROBE = 8'h40;
  localparam logic [7:0] OFF_UTOS = 8'h44;
  // module index field of the address
  localparam int IDX_LO = 8;
  localparam int IDX_HI = 11;

  // reset values
  localparam logic [31:0] CONV_CTL_RST = 32'hfffffc01;
  localparam logic [31:0] SAMPLE_DLY_RST = 32'h00000000;
  localparam logic [31:0] HEADER_RST = 32'h00000001;
  localparam logic [31:0] STROBE_RST = 32'h00fffffc;
  localparam logic UTOS_RST = 1'b0;
  localparam logic [31:0] PORT_DIR_RST = 32'h0000ffff;
  localparam logic [31:0] PORT_POL_RST = 32'h00000000;
  localparam logic [31:0] PORT_CTL_RST = 32'h00000000;
  localparam logic [2:0] DIV_DEFAULT = 3'h5;
  localparam logic [2:0] DIV_ALT = 3'h4;

  // code limits and start patterns
  localparam logic signed [15:0] CODE_MAX = 16'sh7f2e;
  localparam logic signed [15:0] CODE_MIN = -16'sh7f2e;
  localparam logic [7:0] START_RISE = 8'h33;
  localparam logic [7:0] START_FALL = 8'hcc;
  localparam logic [1:0] IDX_SETTLE = 2'h2;

  typedef struct packed {
    logic ph_meta;
    logic ph_sync;
    logic ph_prev;
    logic [3:0] idx_meta;
    logic [3:0] idx_sync;
    logic [3:0] idx;
    logic [1:0] idx_wait;
    logic idx_ok;
    logic [7:0][15:0] smp;
    logic [31:0] fsel;
    logic [31:0] pdir;
    logic [31:0] ppol;
    logic [31:0] pctl;
    logic [2:0] div;
    logic [2:0] dcnt;
    logic [31:0] cctl;
    logic [31:0] cdel;
    logic [31:0] chdr;
    logic [31:0] cstb;
    logic utos;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] start;
    logic sclk;
    logic [15:0] filt;
  } readout_state_t;

endpackage

/* File: verilog/eight_input_adc_readout.sv */
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module eight_input_adc_readout
  import adc_readout_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from outside the clock domain
  input wire logic [3:0] index_switch,
  input wire logic phase_clock,
  // converter front end, on pclk
  input wire logic [7:0] conv_done,
  input wire logic [127:0] conv_code,
  output logic [7:0] conv_start,
  output logic conv_sclk,
  output logic [15:0] filter_select_port
);

  // the index field must fit in the address
  if (ADDR_W < IDX_HI + 1)
  begin : g_addr_check
    $error("ADDR_W too small for the module index field");
  end

  readout_state_t s;
  readout_state_t next_s;

  // raw converter code to clamped signed sample
  function automatic logic [15:0] to_sample(input logic [15:0] raw, input logic utos);
    logic signed [15:0] v;
    v = utos ? {~raw[15], raw[14:0]} : raw; // offset binary flips the msb
    if (v > CODE_MAX)
      return CODE_MAX;
    if (v < CODE_MIN)
      return CODE_MIN;
    return v;
  endfunction

  // per-input clamp of the incoming raw code, one copy per converter
  logic [15:0] clamped [8];
  for (genvar g = 0; g < 8; g++)
  begin : g_clamp
    assign clamped[g] = to_sample(conv_code[16*g +: 16], s.utos);
  end

  logic ph_rise;
  logic ph_fall;
  logic [7:0] off;
  logic hit;
  logic acc_done;
  logic [15:0] fwant;

  // edges of the synchronised phase clock, never the metastable stage
  assign ph_rise = s.ph_sync & ~s.ph_prev;
  assign ph_fall = ~s.ph_sync & s.ph_prev;
  assign off = paddr[7:0];
  assign acc_done = psel & penable & s.pready;
  // driven port bits only; undriven bits read as zero at the pins
  assign fwant = (s.fsel[15:0] ^ s.ppol[15:0]) & s.pdir[15:0];

  // address decode: wrong index or unknown offset is an error answer
  always_comb
  begin
    logic in_map;
    in_map = (off[1:0] == 2'h0) && (off <= OFF_UTOS);
    hit = s.idx_ok && in_map && (paddr[IDX_HI:IDX_LO] == s.idx);
    if (ADDR_W > IDX_HI + 1)
      hit = hit && (paddr >> (IDX_HI + 1)) == '0;
  end

  // whole next state
  always_comb
  begin
    logic [31:0] rd;
    logic bad;
    rd = 32'h00000000;
    bad = 1'b0;
    next_s = s;

    // two flops on each pin before use
    next_s.ph_meta = phase_clock;
    next_s.ph_sync = s.ph_meta;
    next_s.ph_prev = s.ph_sync;
    next_s.idx_meta = index_switch;
    next_s.idx_sync = s.idx_meta;

    // the switch is caught once, after the synchroniser has settled
    if (!s.idx_ok)
    begin
      if (s.idx_wait == IDX_SETTLE)
      begin
        next_s.idx = s.idx_sync;
        next_s.idx_ok = 1'b1;
      end
      else
        next_s.idx_wait = s.idx_wait + 2'h1;
    end

    // start pulses, two groups half a phase period apart
    if (ph_rise)
      next_s.start = START_RISE;
    else if (ph_fall)
      next_s.start = START_FALL;
    else
      next_s.start = 8'h00;

    // converter clock: high for the first div/2 counts, rounded down, of each divider period
    if (s.dcnt >= s.div - 3'h1)
      next_s.dcnt = 3'h0;
    else
      next_s.dcnt = s.dcnt + 3'h1;
    next_s.sclk = next_s.dcnt < (s.div >> 1);

    // result words hold until a conversion finishes
    for (int i = 0; i < 8; i++)
    begin
      if (conv_done[i])
        next_s.smp[i] = clamped[i];
    end

    next_s.filt = fwant;

    // read mux
    if (off < OFF_FILTER)
      rd = {s.smp[off[4:2]], 16'h0000};
    else
    begin
      case (off)
        OFF_FILTER: rd = s.fsel;
        OFF_PORT_DIR: rd = s.pdir;
        OFF_PORT_POL: rd = s.ppol;
        OFF_PORT_CTL: rd = s.pctl;
        OFF_CLK_DIV: rd = {29'h0, s.div};
        OFF_CONV_CTL: rd = s.cctl;
        OFF_SAMPLE_DLY: rd = s.cdel;
        OFF_HEADER: rd = s.chdr;
        OFF_STROBE: rd = s.cstb;
        OFF_UTOS: rd = {31'h0, s.utos};
        default: rd = 32'h00000000;
      endcase
    end

    // writes that are refused: read-only words and unsupported dividers
    if (pwrite)
    begin
      if (off < OFF_FILTER)
        bad = 1'b1;
      else if (off == OFF_CLK_DIV)
        bad = (pwdata[31:0] != {29'h0, DIV_DEFAULT}) &&
              (pwdata[31:0] != {29'h0, DIV_ALT});
    end

    // one wait state, then the registered answer
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready)
    begin
      next_s.pready = 1'b1;
      next_s.pslverr = !hit || bad;
      if (!pwrite)
        next_s.prdata = hit ? rd : 32'h00000000;
    end

    // a write lands on the edge that completes the access
    if (acc_done && pwrite && !s.pslverr)
    begin
      case (off)
        OFF_FILTER: next_s.fsel = pwdata;
        OFF_PORT_DIR: next_s.pdir = pwdata;
        OFF_PORT_POL: next_s.ppol = pwdata;
        OFF_PORT_CTL: next_s.pctl = pwdata;
        OFF_CLK_DIV: next_s.div = pwdata[2:0];
        OFF_CONV_CTL: next_s.cctl = pwdata;
        OFF_SAMPLE_DLY: next_s.cdel = pwdata;
        OFF_HEADER: next_s.chdr = pwdata;
        OFF_STROBE: next_s.cstb = pwdata;
        OFF_UTOS: next_s.utos = pwdata[0];
        default: next_s.fsel = s.fsel;
      endcase
    end
  end

  // state register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.cctl <= CONV_CTL_RST;
      s.cdel <= SAMPLE_DLY_RST;
      s.chdr <= HEADER_RST;
      s.cstb <= STROBE_RST;
      s.utos <= UTOS_RST;
      s.div <= DIV_DEFAULT;
      s.pdir <= PORT_DIR_RST;
      s.ppol <= PORT_POL_RST;
      s.pctl <= PORT_CTL_RST;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign conv_start = s.start;
  assign conv_sclk = s.sclk;
  assign filter_select_port = s.filt;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic all_in_range;
  always_comb
  begin
    all_in_range = 1'b1;
    for (int i = 0; i < 8; i++)
      if ($signed(s.smp[i]) > CODE_MAX || $signed(s.smp[i]) < CODE_MIN)
        all_in_range = 1'b0;
  end

  property p_range;
    all_in_range;
  endproperty
  a_range: assert property (p_range) else $error("sample outside span");

  property p_negative;
    conv_done[0] && !s.utos && $signed(conv_code[15:0]) < 0 &&
      $signed(conv_code[15:0]) >= CODE_MIN
      |=> s.smp[0] == $past(conv_code[15:0]) && s.smp[0][15];
  endproperty
  a_negative: assert property (p_negative) else $error("negative code altered");

  property p_low_half;
    s.pready && !s.pslverr && !pwrite && off < OFF_FILTER |-> s.prdata[15:0] == 16'h0000;
  endproperty
  a_low_half: assert property (p_low_half) else $error("sample low half not zero");

  property p_rise_start;
    ph_rise |=> conv_start == START_RISE ##1 conv_start == 8'h00;
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("rise start wrong");

  property p_fall_start;
    ph_fall |=> conv_start == START_FALL;
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("fall start wrong");

  property p_filter;
    ##1 filter_select_port == $past(fwant);
  endproperty
  a_filter: assert property (p_filter) else $error("filter port mismatch");

  property p_div;
    s.div == DIV_DEFAULT || s.div == DIV_ALT;
  endproperty
  a_div: assert property (p_div) else $error("divider out of set");

  property p_index;
    psel && penable && !s.pready && s.idx_ok && paddr[IDX_HI:IDX_LO] != s.idx
      |=> pready && pslverr;
  endproperty
  a_index: assert property (p_index) else $error("foreign index answered");

  property p_hold;
    !conv_done[3] |=> $stable(s.smp[3]);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without conversion");

  property p_group;
    s.pready && !s.pslverr && !pwrite && off < OFF_FILTER
      |-> s.prdata[31:16] == $past(s.smp[off[4:2]]);
  endproperty
  a_group: assert property (p_group) else $error("result word from wrong slot");

  property p_div_kept;
    acc_done && pwrite && off == OFF_CLK_DIV && s.pslverr |=> $stable(s.div);
  endproperty
  a_div_kept: assert property (p_div_kept) else $error("refused divider landed");

  property p_idx_held;
    s.idx_ok |=> s.idx_ok && $stable(s.idx);
  endproperty
  a_idx_held: assert property (p_idx_held) else $error("module index moved");

  c_read: cover property (psel && penable && pready && !pwrite && !pslverr);
  c_write_div: cover property (acc_done && pwrite && off == OFF_CLK_DIV && !pslverr);
  c_err: cover property (pready && pslverr);
  c_phase: cover property (ph_rise ##[1:1000] ph_fall);

endmodule

/* File: verif/conv_model.sv */
`timescale 1ns/1ps
module conv_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // converter side of the block
  input wire logic [7:0] conv_start,
  input wire logic [127:0] raw_code,
  output logic [7:0] conv_done,
  output logic [127:0] conv_code
);
  // answer one cycle after a start; idle code is inverted so stale reads show
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_done <= 8'h00;
      conv_code <= 128'h0;
    end
    else
    begin
      conv_done <= conv_start;
      conv_code <= (|conv_start) ? raw_code : ~raw_code;
    end
  end
endmodule

/* File: verif/eight_input_adc_readout_tb.sv */
`timescale 1ns/1ps
module eight_input_adc_readout_tb;
  import adc_readout_pkg::*;
  localparam logic [3:0] IDX = 4'h3;
  logic pclk, presetn, psel, penable, pwrite, phase_clock, pready, pslverr, er, conv_sclk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] index_switch;
  logic [7:0] conv_done, conv_start;
  logic [127:0] conv_code, raw_code;
  logic [15:0] filter_select_port;
  int num_errors, samples_checked, cyc;

  eight_input_adc_readout i_eight_input_adc_readout (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .index_switch(index_switch),
    .phase_clock(phase_clock), .conv_done(conv_done), .conv_code(conv_code),
    .conv_start(conv_start), .conv_sclk(conv_sclk), .filter_select_port(filter_select_port));
  conv_model i_conv_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .raw_code(raw_code), .conv_done(conv_done), .conv_code(conv_code));

  // 250 mhz clock
  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // only the bench timeout ends a wait that never gets an answer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task t_reset;
    logic [7:0] off [11];
    logic [31:0] ex [11];
    off = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h00};
    ex = '{32'h0, 32'h0000ffff, 32'h0, 32'h0, 32'h5, 32'hfffffc01, 32'h0, 32'h1,
      32'h00fffffc, 32'h0, 32'h0};
    for (int i = 0; i < 11; i++)
    begin
      apb(0, {IDX, off[i]}, 0);
      check(rd, ex[i], "reset value");
    end
  endtask

  // all four cut-off codes in one word, then polarity inverts the low byte
  task t_filter;
    apb(1, {IDX, 8'h20}, 32'h0000e41b);
    repeat (2) @(posedge pclk);
    #1 check(32'(filter_select_port), 32'he41b, "filter port");
    apb(1, {IDX, 8'h28}, 32'h000000ff);
    repeat (2) @(posedge pclk);
    #1 check(32'(filter_select_port), 32'he4e4, "polarity");
    apb(1, {IDX, 8'h28}, 32'h0);
  endtask

  // converter clock is high for div/2 of every div cycles: 8 of 20 at 5, 10 of 20 at 4
  task t_div;
    int h;
    h = 0;
    repeat (20)
    begin
      @(posedge pclk);
      #1 h += conv_sclk;
    end
    check(32'(h), 32'h8, "sclk high cycles at 5");
    apb(1, {IDX, 8'h30}, 32'h3);
    check(32'(er), 32'h1, "bad divider");
    apb(0, {IDX, 8'h30}, 0);
    check(rd, 32'h5, "divider kept");
    apb(1, {IDX, 8'h30}, 32'h4);
    check(32'(er), 32'h0, "divider 4");
    apb(0, {IDX, 8'h30}, 0);
    check(rd, 32'h4, "divider 4 read");
    h = 0;
    repeat (20)
    begin
      @(posedge pclk);
      #1 h += conv_sclk;
    end
    check(32'(h), 32'ha, "sclk high cycles at 4");
    apb(1, {IDX, 8'h30}, 32'h5);
  endtask

  // offset-binary mode flips the raw msb before clamping; slots 0,1,4,5 on a rise
  task t_utos;
    logic [15:0] e [4];
    e = '{16'h0000, 16'hffff, 16'hff2e, 16'h00d2};
    apb(1, {IDX, 8'h44}, 32'h1);
    @(posedge pclk);
    phase_clock <= 1;
    while (conv_start === 8'h00)
    begin
      @(posedge pclk);
      #1;
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(0, {IDX, 8'(4 * (i + 2 * (i / 2)))}, 0);
      check(rd, {e[i], 16'h0}, "offset binary");
    end
    apb(1, {IDX, 8'h44}, 32'h0);
  endtask

  task t_refuse;
    apb(0, {4'h2, 8'h20}, 0);
    check({31'h0, er}, 32'h1, "foreign index");
    check(rd, 32'h0, "foreign data");
    apb(1, {IDX, 8'h04}, 32'h12345678);
    check({31'h0, er}, 32'h1, "sample write");
    apb(0, {IDX, 8'h48}, 0);
    check({31'h0, er}, 32'h1, "unmapped");
  endtask

  // one phase edge: start pattern, then every slot shows new code or holds
  task t_phase(input logic lvl, input logic [7:0] pat, input logic [7:0] seen);
    logic [15:0] e [8];
    e = '{16'h80d2, 16'h7f2e, 16'hfffb, 16'h1234, 16'h7f2e, 16'h80d2, 16'h0001, 16'h80d2};
    @(posedge pclk);
    phase_clock <= lvl;
    while (conv_start === 8'h00)
    begin
      @(posedge pclk);
      #1;
    end
    check(32'(conv_start), 32'(pat), "start pattern");
    for (int i = 0; i < 8; i++)
    begin
      apb(0, {IDX, 8'(4 * i)}, 0);
      check(rd, seen[i] ? {e[i], 16'h0} : 32'h0, "sample word");
    end
    apb(0, {IDX, 8'h08}, 0);
    check(32'($signed(rd) >>> 16), seen[2] ? 32'hfffffffb : 32'h0, "host shift");
  endtask

  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      results;
    end
  end

  initial
  begin
    {psel, penable, pwrite, phase_clock, presetn} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    index_switch = IDX;
    raw_code = {16'h8001, 16'h0001, 16'h80d2, 16'h7f2e, 16'h1234, 16'hfffb, 16'h7fff,
      16'h8000};
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (5) @(posedge pclk);
    t_reset;
    t_filter;
    t_div;
    t_refuse;
    t_phase(1, 8'h33, 8'h33);
    t_phase(0, 8'hcc, 8'hff);
    t_utos;
    results;
  end
endmodule
